// ---- bench/oid_detect_bench.sv ----
// Register-level bench of the ID pin detection block against a pin model.
`timescale 1ns/1ps
module oid_detect_bench;
	localparam logic [4:0] ctrl_a = oid_pkg::OID_OTG_CTRL_ADDR;
	localparam logic [4:0] rise_a = oid_pkg::OID_INT_EN_RISE_ADDR;
	localparam logic [4:0] fall_a = oid_pkg::OID_INT_EN_FALL_ADDR;
	localparam logic [4:0] rid_a = oid_pkg::OID_RID_CTRL_ADDR;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [4:0] avs_address_i = 5'h00;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [3:0] avs_byteenable_i = 4'hF;
	logic ulpi_sync_mode_i = 1'b0;
	logic [2:0] cable_r = oid_pkg::OID_RID_FLOAT;
	logic [31:0] avs_readdata_o, rd;
	logic avs_waitrequest_o, id_gnd_cmp_i, id_float_cmp_i, id_pullup_en_o, weak_keeper_pullup_o;
	logic rid_meas_en_o, rxcmd_valid_o, rxcmd_alt_int_o;
	logic [4:0] rid_level_i;
	// Fields: cable code, pull-up, expected grounded flag, expected floating flag.
	logic [7:0] cases [6] = '{8'h00, 8'hAC, 8'h60, 8'h10, 8'h58, 8'hBC};
	int fails = 0;
	int samples_checked = 0;
	int cycles = 0;
	int rx_cnt = 0;
	int alt_cnt = 0;
	int b_rx, b_alt, n;
	oid_detect dut_u (.clk_i, .sys_rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
		.avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .id_gnd_cmp_i, .id_float_cmp_i, .rid_level_i,
		.ulpi_sync_mode_i, .id_pullup_en_o, .weak_keeper_pullup_o, .rid_meas_en_o, .rxcmd_valid_o, .rxcmd_alt_int_o);
	oid_id_pin_model pin_u (.cable_i(cable_r), .pullup_i(id_pullup_en_o), .keeper_i(weak_keeper_pullup_o),
		.meas_i(rid_meas_en_o), .gnd_cmp_o(id_gnd_cmp_i), .float_cmp_o(id_float_cmp_i), .level_o(rid_level_i));
	initial begin
		forever #50 clk_i = ~clk_i;
	end
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cycles++;
		if (rxcmd_valid_o === 1'b1)
			rx_cnt++;
		if (rxcmd_valid_o === 1'b1 && rxcmd_alt_int_o === 1'b1)
			alt_cnt++;
		if (cycles == 20000) begin
			fails++;
			tally_and_finish();
		end
	end
	task automatic bus(input logic wr_en, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_byteenable_i <= be;
		avs_write_i <= wr_en;
		avs_read_i <= !wr_en;
		do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
		rd = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'h1);
	endtask
	task automatic chk_rd(input logic [4:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, 4'hF);
		chk(rd, exp);
	endtask
	task automatic settle(input int c);
		repeat (c) @(posedge clk_i);
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		chk_rd(ctrl_a, 32'h0);
		chk_rd(rise_a, 32'h0);
		chk_rd(fall_a, 32'h0);
		for (int i = 0; i < 6; i++) begin
			wr(ctrl_a, {31'h0, cases[i][4]});
			cable_r <= cases[i][7:5];
			settle(16);
			chk({31'h0, id_pullup_en_o}, {31'h0, cases[i][4]});
			chk_rd(oid_pkg::OID_USB_INT_STAT_ADDR, {27'h0, cases[i][3], 4'h0});
			chk_rd(oid_pkg::OID_CARKIT_STAT_ADDR, {31'h0, cases[i][2]});
			chk_rd(oid_pkg::OID_CABLE_STAT_ADDR, (cases[i][3] == cases[i][2]) ?
				{29'h0, 1'b1, cases[i][3], ~cases[i][3]} : 32'h0);
		end
		bus(1'b1, ctrl_a, 32'h0, 4'hE);
		chk_rd(ctrl_a, 32'h1);
		$display("test status table done");
		wr(rise_a, 32'h01);
		wr(fall_a, 32'h01);
		b_alt = alt_cnt;
		cable_r <= oid_pkg::OID_RID_102K;
		settle(12);
		cable_r <= oid_pkg::OID_RID_FLOAT;
		settle(12);
		chk(32'(alt_cnt - b_alt), 32'h2);
		chk_rd(oid_pkg::OID_INT_LATCH_ADDR, 32'h01);
		wr(oid_pkg::OID_INT_LATCH_ADDR, 32'h11);
		chk_rd(oid_pkg::OID_INT_LATCH_ADDR, 32'h0);
		$display("test float events done");
		wr(ctrl_a, 32'h0);
		wr(rise_a, 32'h10);
		wr(fall_a, 32'h10);
		b_rx = rx_cnt;
		b_alt = alt_cnt;
		cable_r <= oid_pkg::OID_RID_200K;
		settle(12);
		cable_r <= oid_pkg::OID_RID_FLOAT;
		settle(12);
		chk(32'(rx_cnt - b_rx), 32'h2);
		chk(32'(alt_cnt - b_alt), 32'h0);
		wr(ctrl_a, 32'h03);
		b_rx = rx_cnt;
		cable_r <= oid_pkg::OID_RID_GROUND;
		settle(12);
		chk(32'(rx_cnt - b_rx), 32'h1);
		$display("test ground events done");
		wr(rid_a, 32'h01);
		settle(8);
		chk({31'h0, rid_meas_en_o}, 32'h0);
		chk_rd(rid_a, 32'h50);
		ulpi_sync_mode_i <= 1'b1;
		for (int c = 0; c < 6; c++) begin
			cable_r <= 3'(c);
			wr(rid_a, 32'h01);
			settle(4);
			n = 0;
			do begin
				bus(1'b0, rid_a, 32'h0, 4'hF);
				n++;
			end while (rd[1] !== 1'b0 && n < 2000);
			chk(rd, {24'h0, 1'b1, 3'(c), 4'h0});
		end
		$display("test converter done");
		tally_and_finish();
	end
endmodule // oid_detect_bench

// ---- bench/oid_detect_checker.sv ----
// Concurrent checks on the ports of the ID pin detection block.
`timescale 1ns/1ps
module oid_detect_checker (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic avs_waitrequest_o,
	input wire logic ulpi_sync_mode_i,
	input wire logic id_pullup_en_o,
	input wire logic weak_keeper_pullup_o,
	input wire logic rid_meas_en_o,
	input wire logic rxcmd_valid_o,
	input wire logic rxcmd_alt_int_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	logic [10:0] meas_cnt_r;
	logic wr_done;
	logic ctrl_wr;
	assign wr_done = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
	assign ctrl_wr = wr_done && avs_address_i == oid_pkg::OID_OTG_CTRL_ADDR;
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			meas_cnt_r <= 11'h000;
		else if (rid_meas_en_o)
			meas_cnt_r <= meas_cnt_r + 11'h001;
		else
			meas_cnt_r <= 11'h000;
	end
	property p_keeper; weak_keeper_pullup_o; endproperty
	a_keeper: assert property (p_keeper) else $error("keeper pull-up off");
	property p_meas_pullup; rid_meas_en_o |-> !id_pullup_en_o; endproperty
	a_meas_pullup: assert property (p_meas_pullup) else $error("pull-up on while measuring");
	property p_meas_len; $fell(rid_meas_en_o) |-> meas_cnt_r >= 11'h3E8 && meas_cnt_r <= 11'h3F0; endproperty
	a_meas_len: assert property (p_meas_len) else $error("measurement length wrong");
	property p_alt; rxcmd_alt_int_o |-> rxcmd_valid_o; endproperty
	a_alt: assert property (p_alt) else $error("alternate flag without rxcmd");
	property p_pulse; rxcmd_valid_o |=> !rxcmd_valid_o; endproperty
	a_pulse: assert property (p_pulse) else $error("rxcmd longer than one cycle");
	property p_pu_on; ctrl_wr && avs_writedata_i[0] |=> id_pullup_en_o || rid_meas_en_o; endproperty
	a_pu_on: assert property (p_pu_on) else $error("pull-up not enabled");
	property p_pu_off; ctrl_wr && !avs_writedata_i[0] |=> !id_pullup_en_o; endproperty
	a_pu_off: assert property (p_pu_off) else $error("pull-up not released");
	property p_async; wr_done && avs_address_i == oid_pkg::OID_RID_CTRL_ADDR && avs_writedata_i[0]
		&& !ulpi_sync_mode_i && !rid_meas_en_o |=> !rid_meas_en_o [*3]; endproperty
	a_async: assert property (p_async) else $error("converter ran outside synchronous mode");
	property p_wait; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
	a_wait: assert property (p_wait) else $error("access not answered");
endmodule // oid_detect_checker
bind oid_detect oid_detect_checker chk_u (.clk_i, .sys_rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
	.avs_writedata_i, .avs_byteenable_i, .avs_waitrequest_o, .ulpi_sync_mode_i, .id_pullup_en_o,
	.weak_keeper_pullup_o, .rid_meas_en_o, .rxcmd_valid_o, .rxcmd_alt_int_o);

// ---- bench/oid_id_pin_model.sv ----
// Behavioural model of the ID pin with its cable, pull-ups and comparators.
`timescale 1ns/1ps
module oid_id_pin_model (
	input wire logic [2:0] cable_i,
	input wire logic pullup_i,
	input wire logic keeper_i,
	input wire logic meas_i,
	output logic gnd_cmp_o,
	output logic float_cmp_o,
	output logic [4:0] level_o
);
	logic open_w;
	assign open_w = cable_i == oid_pkg::OID_RID_FLOAT;
	assign gnd_cmp_o = open_w ? (pullup_i || keeper_i) : (pullup_i && cable_i >= oid_pkg::OID_RID_102K);
	assign float_cmp_o = open_w && (pullup_i || keeper_i);
	// Unless a measurement runs with the pull-up off the levels mean nothing, so a junk pattern is shown.
	assign level_o = (meas_i && !pullup_i) ? 5'h1F >> (3'h5 - cable_i) : 5'h0A;
endmodule // oid_id_pin_model

// ---- core/oid_detect.sv ----
// ID pin detection logic: comparator status, change events, RXCMD requests and resistance converter.
// Function
// - Grounded flag 0 for A, 1 for B.
// - Only grounded or floating are valid cables.
// - Keeper only, ground drop raises interrupt.
// - Resistance coded 000 to 101, pull-up off.
// - Resistance code readable in synchronous mode.
// - Pull-up bit connects internal 100K pull-up.
// - Float changes send RXCMD with alternate interrupt.
// - Flags 11 float, 10 102K, 00 ground.
// - Link clears enables; keeper pulls ID high.
// - Grounded flag is usb status bit 4.
// - Host mode interrupts on grounded change.
// - Floating flag is carkit status bit 0.
`timescale 1ns/1ps
module oid_detect (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic id_gnd_cmp_i,
	input wire logic id_float_cmp_i,
	input wire logic [4:0] rid_level_i,
	input wire logic ulpi_sync_mode_i,
	output logic id_pullup_en_o,
	output logic weak_keeper_pullup_o,
	output logic rid_meas_en_o,
	output logic rxcmd_valid_o,
	output logic rxcmd_alt_int_o
);

	localparam int SYNC_W = 2 + oid_pkg::OID_RID_LEVELS;

	logic [SYNC_W-1:0] sync_in;
	logic [SYNC_W-1:0] sync1_r;
	logic [SYNC_W-1:0] sync2_r;
	logic gnd_prev_r;
	logic float_prev_r;
	logic ack_r;
	logic [31:0] readdata_r;
	logic [7:0] otg_ctrl_r;
	logic [7:0] int_en_rise_r;
	logic [7:0] int_en_fall_r;
	logic [7:0] int_latch_r;
	logic [2:0] rid_code_r;
	logic rid_valid_r;
	logic rid_start_r;
	logic [9:0] settle_cnt_r;
	oid_pkg::oid_rid_state_type rid_state_r;
	oid_pkg::oid_rid_state_type rid_state_nxt;
	logic rxcmd_valid_r;
	logic rxcmd_alt_int_r;
	logic id_gnd_s;
	logic id_float_s;
	logic [4:0] rid_level_s;
	logic gnd_rise;
	logic gnd_fall;
	logic float_rise;
	logic float_fall;
	logic gnd_event;
	logic float_event;
	logic wr_take;
	logic rd_take;
	logic rid_busy;
	logic a_plug;
	logic b_plug;

	// Counts the asserted levels of the thermometer code from the converter comparators.
	function automatic logic [2:0] oid_rid_encode(input logic [4:0] lvl);
		logic [2:0] cnt;
		cnt = 3'h0;
		for (int i = 0; i < oid_pkg::OID_RID_LEVELS; i++) begin
			cnt = cnt + {2'h0, lvl[i]};
		end
		return cnt;
	endfunction

	// Decodes a byte address to a one-hot hit on a given register offset.
	function automatic logic oid_hit(input logic [4:0] addr, input logic [4:0] offset);
		return addr[4:2] == offset[4:2];
	endfunction

	assign sync_in = {rid_level_i, id_float_cmp_i, id_gnd_cmp_i};

	generate
		for (genvar g = 0; g < SYNC_W; g++) begin : g_sync
			always_ff @(posedge clk_i or posedge sys_rst_i) begin
				if (sys_rst_i) begin
					sync1_r[g] <= 1'b0;
					sync2_r[g] <= 1'b0;
				end else begin
					sync1_r[g] <= sync_in[g];
					sync2_r[g] <= sync1_r[g];
				end
			end
		end
	endgenerate

	assign id_gnd_s = sync2_r[0];
	assign id_float_s = sync2_r[1];
	assign rid_level_s = sync2_r[SYNC_W-1:2];

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			gnd_prev_r <= 1'b0;
			float_prev_r <= 1'b0;
		end else begin
			gnd_prev_r <= id_gnd_s;
			float_prev_r <= id_float_s;
		end
	end

	assign gnd_rise = id_gnd_s & ~gnd_prev_r;
	assign gnd_fall = ~id_gnd_s & gnd_prev_r;
	assign float_rise = id_float_s & ~float_prev_r;
	assign float_fall = ~id_float_s & float_prev_r;

	// Grounded changes count in host mode, or while only the keeper holds the pin up.
	assign gnd_event = (otg_ctrl_r[oid_pkg::OID_HOST_MODE_BIT] | ~id_pullup_en_o)
		& ((gnd_rise & int_en_rise_r[oid_pkg::OID_GND_BIT]) | (gnd_fall & int_en_fall_r[oid_pkg::OID_GND_BIT]));
	assign float_event = (float_rise & int_en_rise_r[oid_pkg::OID_FLOAT_BIT])
		| (float_fall & int_en_fall_r[oid_pkg::OID_FLOAT_BIT]);

	// Only a grounded pin or a floating pin is a legal OTG cable state.
	assign a_plug = ~id_gnd_s & ~id_float_s;
	assign b_plug = id_gnd_s & id_float_s;

	// The slave answers every access in its second cycle.
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
	assign avs_readdata_o = readdata_r;
	assign wr_take = avs_write_i & ack_r & avs_byteenable_i[0];
	assign rd_take = avs_read_i & ~ack_r;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			readdata_r <= 32'h00000000;
		end else if (rd_take) begin
			readdata_r <= 32'h00000000;
			if (oid_hit(avs_address_i, oid_pkg::OID_OTG_CTRL_ADDR)) begin
				readdata_r[7:0] <= otg_ctrl_r;
			end
			if (oid_hit(avs_address_i, oid_pkg::OID_INT_EN_RISE_ADDR)) begin
				readdata_r[7:0] <= int_en_rise_r;
			end
			if (oid_hit(avs_address_i, oid_pkg::OID_INT_EN_FALL_ADDR)) begin
				readdata_r[7:0] <= int_en_fall_r;
			end
			if (oid_hit(avs_address_i, oid_pkg::OID_USB_INT_STAT_ADDR)) begin
				readdata_r[oid_pkg::OID_GND_BIT] <= id_gnd_s;
			end
			if (oid_hit(avs_address_i, oid_pkg::OID_CARKIT_STAT_ADDR)) begin
				readdata_r[oid_pkg::OID_FLOAT_BIT] <= id_float_s;
			end
			if (oid_hit(avs_address_i, oid_pkg::OID_INT_LATCH_ADDR)) begin
				readdata_r[7:0] <= int_latch_r;
			end
			if (oid_hit(avs_address_i, oid_pkg::OID_RID_CTRL_ADDR)) begin
				readdata_r[oid_pkg::OID_RID_BUSY_BIT] <= rid_busy;
				readdata_r[oid_pkg::OID_RID_CODE_LSB +: 3] <= rid_code_r;
				readdata_r[oid_pkg::OID_RID_VALID_BIT] <= rid_valid_r;
			end
			if (oid_hit(avs_address_i, oid_pkg::OID_CABLE_STAT_ADDR)) begin
				readdata_r[oid_pkg::OID_A_PLUG_BIT] <= a_plug;
				readdata_r[oid_pkg::OID_B_PLUG_BIT] <= b_plug;
				readdata_r[oid_pkg::OID_VALID_CABLE_BIT] <= a_plug | b_plug;
			end
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			otg_ctrl_r <= oid_pkg::OID_OTG_CTRL_RST;
			int_en_rise_r <= oid_pkg::OID_INT_EN_RST;
			int_en_fall_r <= oid_pkg::OID_INT_EN_RST;
		end else if (wr_take) begin
			if (oid_hit(avs_address_i, oid_pkg::OID_OTG_CTRL_ADDR)) begin
				otg_ctrl_r <= {6'h00, avs_writedata_i[1:0]};
			end
			if (oid_hit(avs_address_i, oid_pkg::OID_INT_EN_RISE_ADDR)) begin
				int_en_rise_r <= {3'h0, avs_writedata_i[4], 3'h0, avs_writedata_i[0]};
			end
			if (oid_hit(avs_address_i, oid_pkg::OID_INT_EN_FALL_ADDR)) begin
				int_en_fall_r <= {3'h0, avs_writedata_i[4], 3'h0, avs_writedata_i[0]};
			end
		end
	end

	// Sticky change flags; a new event in the clearing cycle survives.
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			int_latch_r <= 8'h00;
		end else begin
			if (wr_take && oid_hit(avs_address_i, oid_pkg::OID_INT_LATCH_ADDR)) begin
				int_latch_r <= int_latch_r & ~avs_writedata_i[7:0];
			end
			if (gnd_event) begin
				int_latch_r[oid_pkg::OID_GND_BIT] <= 1'b1;
			end
			if (float_event) begin
				int_latch_r[oid_pkg::OID_FLOAT_BIT] <= 1'b1;
			end
		end
	end

	// One-cycle RXCMD request; float changes carry the alternate interrupt bit.
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rxcmd_valid_r <= 1'b0;
			rxcmd_alt_int_r <= 1'b0;
		end else begin
			rxcmd_valid_r <= gnd_event | float_event;
			rxcmd_alt_int_r <= float_event;
		end
	end

	assign rxcmd_valid_o = rxcmd_valid_r;
	assign rxcmd_alt_int_o = rxcmd_alt_int_r;

	// Start request for the converter, honoured only in synchronous mode.
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rid_start_r <= 1'b0;
		end else begin
			rid_start_r <= wr_take && oid_hit(avs_address_i, oid_pkg::OID_RID_CTRL_ADDR)
				&& avs_writedata_i[oid_pkg::OID_RID_START_BIT] && ulpi_sync_mode_i;
		end
	end

	always_comb begin
		rid_state_nxt = rid_state_r;
		case (rid_state_r)
			oid_pkg::OID_RID_IDLE: begin
				if (rid_start_r) begin
					rid_state_nxt = oid_pkg::OID_RID_SETTLE;
				end
			end
			oid_pkg::OID_RID_SETTLE: begin
				if (settle_cnt_r == oid_pkg::OID_RID_SETTLE_LAST) begin
					rid_state_nxt = oid_pkg::OID_RID_SAMPLE;
				end
			end
			oid_pkg::OID_RID_SAMPLE: begin
				rid_state_nxt = oid_pkg::OID_RID_DONE;
			end
			oid_pkg::OID_RID_DONE: begin
				rid_state_nxt = oid_pkg::OID_RID_IDLE;
			end
			default: begin
				rid_state_nxt = oid_pkg::OID_RID_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rid_state_r <= oid_pkg::OID_RID_IDLE;
		end else begin
			rid_state_r <= rid_state_nxt;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			settle_cnt_r <= 10'h000;
		end else if (rid_state_r == oid_pkg::OID_RID_SETTLE) begin
			settle_cnt_r <= settle_cnt_r + 10'h001;
		end else begin
			settle_cnt_r <= 10'h000;
		end
	end

	// The code is taken once the pin has settled with the main pull-up off.
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rid_code_r <= oid_pkg::OID_RID_FLOAT;
			rid_valid_r <= 1'b0;
		end else if (rid_state_r == oid_pkg::OID_RID_SAMPLE) begin
			rid_code_r <= oid_rid_encode(rid_level_s);
			rid_valid_r <= 1'b1;
		end else if (rid_start_r) begin
			rid_valid_r <= 1'b0;
		end
	end

	assign rid_busy = rid_state_r != oid_pkg::OID_RID_IDLE;
	assign rid_meas_en_o = rid_busy;
	// The internal pull-up follows the control bit except during a measurement.
	assign id_pullup_en_o = otg_ctrl_r[oid_pkg::OID_PULLUP_BIT] & ~rid_busy;
	// The keeper stays on so a removed cable lets the pin rise.
	assign weak_keeper_pullup_o = 1'b1;

endmodule // oid_detect

// ---- core/oid_pkg.sv ----
// Package with register map, field positions, codes and timing for the ID pin detection block.
package oid_pkg;
	// Register byte offsets.
	localparam logic [4:0] OID_OTG_CTRL_ADDR = 5'h00;
	localparam logic [4:0] OID_INT_EN_RISE_ADDR = 5'h04;
	localparam logic [4:0] OID_INT_EN_FALL_ADDR = 5'h08;
	localparam logic [4:0] OID_USB_INT_STAT_ADDR = 5'h0C;
	localparam logic [4:0] OID_CARKIT_STAT_ADDR = 5'h10;
	localparam logic [4:0] OID_INT_LATCH_ADDR = 5'h14;
	localparam logic [4:0] OID_RID_CTRL_ADDR = 5'h18;
	localparam logic [4:0] OID_CABLE_STAT_ADDR = 5'h1C;

	// Field positions.
	localparam int OID_PULLUP_BIT = 0;
	localparam int OID_HOST_MODE_BIT = 1;
	localparam int OID_GND_BIT = 4;
	localparam int OID_FLOAT_BIT = 0;
	localparam int OID_RID_START_BIT = 0;
	localparam int OID_RID_BUSY_BIT = 1;
	localparam int OID_RID_VALID_BIT = 7;
	localparam int OID_RID_CODE_LSB = 4;
	localparam int OID_A_PLUG_BIT = 0;
	localparam int OID_B_PLUG_BIT = 1;
	localparam int OID_VALID_CABLE_BIT = 2;

	// Reset values.
	localparam logic [7:0] OID_OTG_CTRL_RST = 8'h00;
	localparam logic [7:0] OID_INT_EN_RST = 8'h00;

	// Resistance codes.
	localparam logic [2:0] OID_RID_GROUND = 3'h0;
	localparam logic [2:0] OID_RID_75R = 3'h1;
	localparam logic [2:0] OID_RID_102K = 3'h2;
	localparam logic [2:0] OID_RID_200K = 3'h3;
	localparam logic [2:0] OID_RID_440K = 3'h4;
	localparam logic [2:0] OID_RID_FLOAT = 3'h5;
	localparam int OID_RID_LEVELS = 5;

	// Timing.
	localparam int OID_CLK_PERIOD_NS = 100;
	localparam int OID_RID_SETTLE_NS = 100000;
	localparam int OID_RID_SETTLE_CYC = (OID_RID_SETTLE_NS + OID_CLK_PERIOD_NS - 1) / OID_CLK_PERIOD_NS;
	localparam logic [9:0] OID_RID_SETTLE_LAST = 10'(OID_RID_SETTLE_CYC - 1);

	// Converter sequence.
	typedef enum logic [3:0] {
		OID_RID_IDLE = 4'h1,
		OID_RID_SETTLE = 4'h2,
		OID_RID_SAMPLE = 4'h4,
		OID_RID_DONE = 4'h8
	} oid_rid_state_type;
endpackage
